// ---- core/rimr_pkg.sv ----
// Purpose: shared constants and types for the receive ring/recombiner register bank
// Assumes: 16 receive links, 8 groups, microprocessor port with 12-bit word addresses
// Notes: register offsets are word addresses on the processor port
package rimr_pkg;
   localparam int NLINK = 16;
   localparam int NGRP = 8;
   localparam int NPAIR = 8;
   localparam int NINT = 4;
   localparam int FDEPTH = 4;

   localparam logic [11:0] A_FLAGS = 12'h0107;
   localparam logic [11:0] A_DEBUG = 12'h0108;
   localparam logic [11:0] A_WORD0 = 12'h0140;
   localparam logic [11:0] A_RCTL = 12'h0180;
   localparam logic [11:0] A_TXR0 = 12'h0181;
   localparam logic [11:0] A_RXR0 = 12'h01c0;
   localparam logic [11:0] A_RCB0 = 12'h0201;
   localparam logic [11:0] A_REF0 = 12'h0209;
   localparam logic [11:0] A_INT0 = 12'h0219;
   localparam logic [11:0] A_EXT = 12'h0280;

   localparam int DBG_EN = 0;
   localparam int DBG_ICP = 1;
   localparam int RC_MASTER = 0;
   localparam int RC_INIT = 1;
   localparam int RC_EN = 2;
   localparam int RB_EN_LO = 4;
   localparam int RB_EN_HI = 12;
   localparam int RB_GRP_LO = 0;
   localparam int RB_GRP_HI = 8;
   localparam int REF_AUTO = 4;
   localparam int INT_LO = 0;
   localparam int INT_HI = 8;
   localparam int EXT_RDY = 7;
   localparam int EXT_TOG = 6;
   localparam int EXT_DIR = 5;
   localparam int EXT_NOACC = 1;

   localparam logic [15:0] RB_MASK = 16'h1717;
   localparam logic [15:0] INT_MASK = 16'h0f0f;
   localparam logic [15:0] WORD_RST = 16'h8000;
   localparam logic [15:0] INT_RST = 16'h0c0c;
   localparam logic [3:0] INT_RSVD = 4'hf;
   localparam int INT_EXP_BASE = 8;
   localparam int INT_CW = 23;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } rimr_cpu_req_t;

   typedef struct packed {
      logic last;
      logic [5:0] ofs;
      logic [7:0] val;
   } rimr_fent_t;

   typedef struct packed {
      logic valid;
      logic [3:0] link;
      rimr_fent_t ent;
   } rimr_chg_t;

   typedef struct packed {
      logic atm_en;
      logic [4:0] atm_addr;
      logic tdm_en;
      logic [4:0] tdm_addr;
   } rimr_route_t;

   typedef struct packed {
      logic dir;
      logic [1:0] op;
   } rimr_ext_cmd_t;

   typedef enum logic {EXT_IDLE, EXT_BUSY} rimr_ext_st_t;
endpackage

// ---- core/rimr_regs.sv ----
// Purpose: receive ring, recombiner and change-fifo register bank on the processor port
// Assumes: processor port and change feed run on core_clk_in; reads answer one cycle later
// Notes: reading a change-fifo word pops it; pushes to a full link fifo are dropped
module rimr_regs (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire rimr_pkg::rimr_cpu_req_t cpu_req_in,
   output logic [15:0] cpu_rdata_out,
   output logic cpu_rvalid_out,
   input wire rimr_pkg::rimr_chg_t chg_in,
   input wire logic ext_done_in,
   output logic ext_start_out,
   output rimr_pkg::rimr_ext_cmd_t ext_cmd_out,
   output logic debug_en_out,
   output logic cmp_icp_only_out,
   output logic ring_master_out,
   output logic ring_drive_en_out,
   output logic ring_init_hdr_out,
   output rimr_pkg::rimr_route_t [15:0] tx_route_out,
   output rimr_pkg::rimr_route_t [15:0] rx_route_out,
   output logic [15:0][2:0] link_grp_out,
   output logic [15:0] link_recomb_en_out,
   output logic [7:0] ref_auto_out,
   output logic [7:0][3:0] ref_link_out,
   output logic [7:0] int_tick_out
);
   logic [15:0] debug_ff;
   logic [15:0] rctl_ff;
   logic [15:0][11:0] txr_ff;
   logic [15:0][11:0] rxr_ff;
   logic [7:0][15:0] rcb_ff;
   logic [7:0][4:0] ref_ff;
   logic [3:0][15:0] int_ff;
   logic ext_rdy_ff;
   logic ext_tog_ff;
   rimr_pkg::rimr_ext_st_t ext_st_ff;
   rimr_pkg::rimr_ext_cmd_t ext_cmd_ff;
   logic [15:0] nonempty;
   logic [15:0][15:0] word_rd;
   logic [15:0] rdata;
   logic wr;
   logic rd;
   logic [11:0] a;
   logic ext_wr;
   logic rdy_set;

   assign wr = cpu_req_in.wr;
   assign rd = cpu_req_in.rd;
   assign a = cpu_req_in.addr;
   assign ext_wr = wr && a == rimr_pkg::A_EXT && ext_st_ff == rimr_pkg::EXT_IDLE;

   // per-link change fifos
   for (genvar i = 0; i < rimr_pkg::NLINK; i++) begin : g_fifo
      rimr_pkg::rimr_fent_t mem_ff [rimr_pkg::FDEPTH];
      logic [1:0] wp_ff;
      logic [1:0] rp_ff;
      logic [2:0] cnt_ff;
      logic push;
      logic pop;
      assign push = chg_in.valid && chg_in.link == 4'(i) && cnt_ff != 3'(rimr_pkg::FDEPTH);
      assign pop = rd && a == rimr_pkg::A_WORD0 + 12'(i) && cnt_ff != 3'h0;
      always_ff @(posedge core_clk_in) begin
         if (!rst_b_in) begin
            wp_ff <= 2'h0;
            rp_ff <= 2'h0;
            cnt_ff <= 3'h0;
         end else begin
            if (push) begin
               mem_ff[wp_ff] <= chg_in.ent;
               wp_ff <= wp_ff + 2'h1;
            end
            if (pop) begin
               rp_ff <= rp_ff + 2'h1;
            end
            cnt_ff <= cnt_ff + 3'(push) - 3'(pop);
         end
      end
      assign nonempty[i] = cnt_ff != 3'h0;
      // bit 15 says whether entries remain behind this one; bit 14, 13:8, 7:0 from the entry
      assign word_rd[i] = (cnt_ff == 3'h0) ? rimr_pkg::WORD_RST :
                          {cnt_ff > 3'h1, mem_ff[rp_ff]};
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         debug_ff <= 16'h0000;
         rctl_ff <= 16'h0000;
      end else if (wr) begin
         if (a == rimr_pkg::A_DEBUG) begin
            debug_ff <= cpu_req_in.wdata & 16'h0003;
         end
         if (a == rimr_pkg::A_RCTL) begin
            rctl_ff <= cpu_req_in.wdata & 16'h0007;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         txr_ff <= '0;
         rxr_ff <= '0;
      end else if (wr) begin
         for (int i = 0; i < rimr_pkg::NLINK; i++) begin
            if (a == rimr_pkg::A_TXR0 + 12'(i)) begin
               txr_ff[i] <= cpu_req_in.wdata[11:0];
            end
            if (a == rimr_pkg::A_RXR0 + 12'(i)) begin
               rxr_ff[i] <= cpu_req_in.wdata[11:0];
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         rcb_ff <= '0;
         ref_ff <= '0;
         int_ff <= {rimr_pkg::NINT{rimr_pkg::INT_RST}};
      end else if (wr) begin
         for (int p = 0; p < rimr_pkg::NPAIR; p++) begin
            if (a == rimr_pkg::A_RCB0 + 12'(p)) begin
               rcb_ff[p] <= cpu_req_in.wdata & rimr_pkg::RB_MASK;
            end
            if (a == rimr_pkg::A_REF0 + 12'(p)) begin
               ref_ff[p] <= cpu_req_in.wdata[4:0];
            end
         end
         for (int q = 0; q < rimr_pkg::NINT; q++) begin
            if (a == rimr_pkg::A_INT0 + 12'(q)) begin
               int_ff[q] <= cpu_req_in.wdata & rimr_pkg::INT_MASK;
            end
         end
      end
   end

   // external memory access handshake
   assign rdy_set = (ext_st_ff == rimr_pkg::EXT_BUSY && ext_done_in) ||
                    (ext_st_ff == rimr_pkg::EXT_IDLE && !ext_rdy_ff && !ext_wr);
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         ext_st_ff <= rimr_pkg::EXT_IDLE;
         ext_rdy_ff <= 1'b1;
         ext_tog_ff <= 1'b0;
         ext_cmd_ff <= '0;
         ext_start_out <= 1'b0;
      end else begin
         ext_start_out <= 1'b0;
         if (ext_wr) begin
            ext_rdy_ff <= 1'b0;
            ext_cmd_ff <= {cpu_req_in.wdata[rimr_pkg::EXT_DIR], cpu_req_in.wdata[1:0]};
            if (!cpu_req_in.wdata[rimr_pkg::EXT_NOACC]) begin
               ext_st_ff <= rimr_pkg::EXT_BUSY;
               ext_start_out <= 1'b1;
            end
         end else if (rdy_set) begin
            ext_rdy_ff <= 1'b1;
            ext_tog_ff <= !ext_tog_ff;
            ext_st_ff <= rimr_pkg::EXT_IDLE;
         end
      end
   end

   // integration period timers
   for (genvar g = 0; g < rimr_pkg::NGRP; g++) begin : g_int
      logic [3:0] code;
      logic [rimr_pkg::INT_CW-1:0] cnt_ff;
      logic [rimr_pkg::INT_CW-1:0] term;
      assign code = (g < rimr_pkg::NINT) ? int_ff[g % rimr_pkg::NINT][rimr_pkg::INT_LO +: 4] :
                                           int_ff[g % rimr_pkg::NINT][rimr_pkg::INT_HI +: 4];
      // shift amount kept at five bits so codes 8 to 14 do not wrap
      assign term = rimr_pkg::INT_CW'((24'h00_0001 << (5'(code) + 5'(rimr_pkg::INT_EXP_BASE))) - 24'h00_0001);
      always_ff @(posedge core_clk_in) begin
         if (!rst_b_in || code == rimr_pkg::INT_RSVD) begin
            cnt_ff <= '0;
            int_tick_out[g] <= 1'b0;
         end else begin
            int_tick_out[g] <= cnt_ff >= term;
            cnt_ff <= (cnt_ff >= term) ? '0 : cnt_ff + 1'b1;
         end
      end
   end

   // read path
   always_comb begin
      rdata = 16'h0000;
      if (a == rimr_pkg::A_FLAGS) begin
         rdata = nonempty;
      end else if (a == rimr_pkg::A_DEBUG) begin
         rdata = debug_ff;
      end else if (a == rimr_pkg::A_RCTL) begin
         rdata = rctl_ff;
      end else if (a == rimr_pkg::A_EXT) begin
         rdata = {8'h00, ext_rdy_ff, ext_tog_ff, ext_cmd_ff.dir, 3'h0, ext_cmd_ff.op};
      end
      for (int i = 0; i < rimr_pkg::NLINK; i++) begin
         if (a == rimr_pkg::A_WORD0 + 12'(i)) begin
            rdata = word_rd[i];
         end
         if (a == rimr_pkg::A_TXR0 + 12'(i)) begin
            rdata = {4'h0, txr_ff[i]};
         end
         if (a == rimr_pkg::A_RXR0 + 12'(i)) begin
            rdata = {4'h0, rxr_ff[i]};
         end
      end
      for (int p = 0; p < rimr_pkg::NPAIR; p++) begin
         if (a == rimr_pkg::A_RCB0 + 12'(p)) begin
            rdata = rcb_ff[p];
         end
         if (a == rimr_pkg::A_REF0 + 12'(p)) begin
            rdata = {11'h000, ref_ff[p]};
         end
      end
      for (int q = 0; q < rimr_pkg::NINT; q++) begin
         if (a == rimr_pkg::A_INT0 + 12'(q)) begin
            rdata = int_ff[q];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         cpu_rdata_out <= 16'h0000;
         cpu_rvalid_out <= 1'b0;
      end else begin
         cpu_rvalid_out <= rd;
         if (rd) begin
            cpu_rdata_out <= rdata;
         end
      end
   end

   // registered copies of the configuration for the datapath
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         debug_en_out <= 1'b0;
         cmp_icp_only_out <= 1'b0;
         ring_master_out <= 1'b0;
         ring_drive_en_out <= 1'b0;
         ring_init_hdr_out <= 1'b0;
         tx_route_out <= '0;
         rx_route_out <= '0;
         link_grp_out <= '0;
         link_recomb_en_out <= '0;
         ref_auto_out <= '0;
         ref_link_out <= '0;
         ext_cmd_out <= '0;
      end else begin
         debug_en_out <= debug_ff[rimr_pkg::DBG_EN];
         cmp_icp_only_out <= debug_ff[rimr_pkg::DBG_ICP];
         ring_master_out <= rctl_ff[rimr_pkg::RC_MASTER];
         ring_drive_en_out <= rctl_ff[rimr_pkg::RC_EN];
         ring_init_hdr_out <= rctl_ff[rimr_pkg::RC_MASTER] && rctl_ff[rimr_pkg::RC_INIT];
         tx_route_out <= txr_ff;
         rx_route_out <= rxr_ff;
         for (int p = 0; p < rimr_pkg::NPAIR; p++) begin
            link_grp_out[p] <= rcb_ff[p][rimr_pkg::RB_GRP_LO +: 3];
            link_grp_out[p + rimr_pkg::NPAIR] <= rcb_ff[p][rimr_pkg::RB_GRP_HI +: 3];
            link_recomb_en_out[p] <= rcb_ff[p][rimr_pkg::RB_EN_LO];
            link_recomb_en_out[p + rimr_pkg::NPAIR] <= rcb_ff[p][rimr_pkg::RB_EN_HI];
            ref_auto_out[p] <= ref_ff[p][rimr_pkg::REF_AUTO];
            ref_link_out[p] <= ref_ff[p][3:0];
         end
         ext_cmd_out <= ext_cmd_ff;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   property p_flags;
      rd && a == rimr_pkg::A_FLAGS |=> cpu_rdata_out == $past(nonempty);
   endproperty
   a_flags: assert property (p_flags) else $error("flag read mismatch");

   property p_cmp;
      wr && a == rimr_pkg::A_DEBUG |=> ##1 cmp_icp_only_out == $past(cpu_req_in.wdata[1], 2);
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare scope not applied");

   property p_dbg;
      wr && a == rimr_pkg::A_DEBUG |=> ##1 debug_en_out == $past(cpu_req_in.wdata[0], 2);
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug enable not applied");

   property p_empty_word;
      rd && a == rimr_pkg::A_WORD0 && !nonempty[0] |=> cpu_rdata_out == 16'h8000;
   endproperty
   a_empty_word: assert property (p_empty_word) else $error("empty word not 8000");

   property p_ring_oe;
      wr && a == rimr_pkg::A_RCTL |=> ##1 ring_drive_en_out == $past(cpu_req_in.wdata[2], 2);
   endproperty
   a_ring_oe: assert property (p_ring_oe) else $error("ring drive enable wrong");

   property p_init;
      wr && a == rimr_pkg::A_RCTL |=> ##1
         ring_init_hdr_out == ($past(cpu_req_in.wdata[1], 2) && $past(cpu_req_in.wdata[0], 2));
   endproperty
   a_init: assert property (p_init) else $error("init headers from non-master");

   property p_grp;
      wr && a == rimr_pkg::A_RCB0 |=> ##1 link_grp_out[8] == $past(cpu_req_in.wdata[10:8], 2);
   endproperty
   a_grp: assert property (p_grp) else $error("upper link group wrong");

   property p_int0;
      int_tick_out[0] && $past(g_int[0].code) == 4'h0 |-> $past(g_int[0].cnt_ff) == 23'h00_00ff;
   endproperty
   a_int0: assert property (p_int0) else $error("code 0 period not 256");

   property p_rdy_clr;
      ext_wr |=> !ext_rdy_ff;
   endproperty
   a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared on write");

   property p_tog;
      $rose(ext_rdy_ff) |-> ext_tog_ff != $past(ext_tog_ff);
   endproperty
   a_tog: assert property (p_tog) else $error("toggle missed ready rise");

   property p_noacc;
      ext_wr && cpu_req_in.wdata[1] |=> !ext_start_out ##1 ext_rdy_ff;
   endproperty
   a_noacc: assert property (p_noacc) else $error("no-access write misbehaved");
endmodule

// ---- dv/test_rimr_regs.sv ----
// Purpose: self-checking bench for the receive ring/recombiner register bank
// Assumes: reads answer within three cycles, config outputs settle within three cycles of a write
// Notes: shadow arrays and per-link queues model the bank; inputs change on the falling edge
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end
module test_rimr_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   rimr_pkg::rimr_cpu_req_t cpu_req_in = '0;
   rimr_pkg::rimr_chg_t chg_in = '0;
   logic ext_done_in = 1'b0;
   logic [15:0] cpu_rdata_out;
   logic cpu_rvalid_out, ext_start_out, debug_en_out, cmp_icp_only_out;
   logic ring_master_out, ring_drive_en_out, ring_init_hdr_out;
   rimr_pkg::rimr_ext_cmd_t ext_cmd_out;
   rimr_pkg::rimr_route_t [15:0] tx_route_out, rx_route_out;
   logic [15:0][2:0] link_grp_out;
   logic [15:0] link_recomb_en_out;
   logic [7:0] ref_auto_out;
   logic [7:0][3:0] ref_link_out;
   logic [7:0] int_tick_out;
   int n_mismatch = 0, num_checks = 0, n_cyc = 0, n_start = 0, n_rsvd = 0;
   logic [15:0] txr[16], rxr[16], rcb[8], refs[8], intr[4], dbg, rctl, d, w;
   int q[16][$];
   logic tog = 1'b0;

   rimr_regs dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .cpu_req_in(cpu_req_in),
      .cpu_rdata_out(cpu_rdata_out), .cpu_rvalid_out(cpu_rvalid_out), .chg_in(chg_in),
      .ext_done_in(ext_done_in), .ext_start_out(ext_start_out), .ext_cmd_out(ext_cmd_out),
      .debug_en_out(debug_en_out), .cmp_icp_only_out(cmp_icp_only_out), .ring_master_out(ring_master_out),
      .ring_drive_en_out(ring_drive_en_out), .ring_init_hdr_out(ring_init_hdr_out),
      .tx_route_out(tx_route_out), .rx_route_out(rx_route_out), .link_grp_out(link_grp_out),
      .link_recomb_en_out(link_recomb_en_out), .ref_auto_out(ref_auto_out), .ref_link_out(ref_link_out),
      .int_tick_out(int_tick_out));

   always #50 core_clk_in = ~core_clk_in;

   always @(posedge core_clk_in) begin
      n_cyc++;
      if (ext_start_out === 1'b1) n_start++;
      if ((int_tick_out & 8'hdc) !== 8'h00) n_rsvd++;
      if (n_cyc == 30000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic results();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      cpu_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge core_clk_in);
      cpu_req_in.wr = 1'b0;
      @(negedge core_clk_in);
   endtask

   task automatic rd(input logic [11:0] a, output logic [15:0] v);
      int n;
      n = 0;
      cpu_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge core_clk_in);
      cpu_req_in.rd = 1'b0;
      while (cpu_rvalid_out !== 1'b1 && n < 3) begin
         @(negedge core_clk_in);
         n++;
      end
      v = cpu_rdata_out;
      `CHK(n < 3, 1'b1)
      @(negedge core_clk_in);
   endtask

   task automatic push(input int l);
      rimr_pkg::rimr_fent_t e;
      e = '{last: 1'($urandom), ofs: 6'(1 + $urandom % 53), val: 8'($urandom)};
      chg_in = '{valid: 1'b1, link: 4'(l), ent: e};
      if (q[l].size() < rimr_pkg::FDEPTH) q[l].push_back(int'(e));
      @(negedge core_clk_in);
      chg_in.valid = 1'b0;
      @(negedge core_clk_in);
   endtask

   task automatic pop(input int l);
      logic [15:0] e;
      e = rimr_pkg::WORD_RST;
      if (q[l].size() > 0) begin
         e = 16'(q[l].pop_front());
         e[15] = (q[l].size() > 0);
      end
      rd(12'(rimr_pkg::A_WORD0 + l), d);
      `CHK(d, e)
   endtask

   task automatic period(input int g, input int exp);
      int n;
      n = 0;
      while (int_tick_out[g] !== 1'b1 && n < 1100) begin
         @(negedge core_clk_in);
         n++;
      end
      n = 0;
      do begin
         @(negedge core_clk_in);
         n++;
      end while (int_tick_out[g] !== 1'b1 && n < 1100);
      `CHK(n, exp)
   endtask

   task automatic ext(input logic [15:0] v, input logic acc);
      int s, n;
      s = n_start;
      wr(rimr_pkg::A_EXT, v);
      rd(rimr_pkg::A_EXT, d);
      if (acc) begin
         `CHK(d, {8'h00, 1'b0, tog, v[5], 3'b000, v[1:0]})
         wr(rimr_pkg::A_EXT, v ^ 16'h0020);
         `CHK(ext_cmd_out, {v[5], v[1:0]})
         ext_done_in = 1'b1;
         @(negedge core_clk_in);
         ext_done_in = 1'b0;
      end
      repeat (3) @(negedge core_clk_in);
      tog = ~tog;
      n = n_start - s;
      `CHK(n, int'(acc))
      rd(rimr_pkg::A_EXT, d);
      `CHK(d, {8'h00, 1'b1, tog, v[5], 3'b000, v[1:0]})
   endtask

   initial begin
      void'($urandom(32'h8af1));
      repeat (8) @(negedge core_clk_in);
      rst_b_in = 1'b1;
      intr = '{16'h0f00, 16'h0001, 16'h0f0f, 16'h0b09};
      for (int g = 0; g < 4; g++) wr(12'(rimr_pkg::A_INT0 + g), intr[g]);
      rd(rimr_pkg::A_FLAGS, d);
      `CHK(d, 16'h0000)
      rd(rimr_pkg::A_WORD0, d);
      `CHK(d, rimr_pkg::WORD_RST)
      rd(rimr_pkg::A_EXT, d);
      `CHK(d, 16'h0080)
      rd(12'h0300, d);
      `CHK(d, 16'h0000)
      // configuration registers with random contents
      dbg = 16'($urandom);
      rctl = 16'($urandom) | 16'h0003;
      wr(rimr_pkg::A_DEBUG, dbg);
      wr(rimr_pkg::A_RCTL, rctl);
      for (int i = 0; i < 16; i++) begin
         txr[i] = 16'($urandom);
         rxr[i] = 16'($urandom);
         wr(12'(rimr_pkg::A_TXR0 + i), txr[i]);
         wr(12'(rimr_pkg::A_RXR0 + i), rxr[i]);
      end
      for (int p = 0; p < 8; p++) begin
         rcb[p] = 16'($urandom);
         refs[p] = 16'($urandom);
         wr(12'(rimr_pkg::A_RCB0 + p), rcb[p]);
         wr(12'(rimr_pkg::A_REF0 + p), refs[p]);
      end
      wr(12'h0300, 16'hffff);
      repeat (3) @(negedge core_clk_in);
      rd(rimr_pkg::A_DEBUG, d);
      `CHK(d, dbg & 16'h0003)
      `CHK({cmp_icp_only_out, debug_en_out}, dbg[1:0])
      rd(rimr_pkg::A_RCTL, d);
      `CHK(d, rctl & 16'h0007)
      `CHK({ring_drive_en_out, ring_init_hdr_out, ring_master_out}, {rctl[2], rctl[1] & rctl[0], rctl[0]})
      for (int i = 0; i < 16; i++) begin
         rd(12'(rimr_pkg::A_TXR0 + i), d);
         `CHK(d, txr[i] & 16'h0fff)
         `CHK(tx_route_out[i], txr[i][11:0])
         rd(12'(rimr_pkg::A_RXR0 + i), d);
         `CHK(d, rxr[i] & 16'h0fff)
         `CHK(rx_route_out[i], rxr[i][11:0])
      end
      for (int p = 0; p < 8; p++) begin
         rd(12'(rimr_pkg::A_RCB0 + p), d);
         `CHK(d, rcb[p] & rimr_pkg::RB_MASK)
         `CHK({link_grp_out[p + 8], link_grp_out[p]}, {rcb[p][10:8], rcb[p][2:0]})
         `CHK({link_recomb_en_out[p + 8], link_recomb_en_out[p]}, {rcb[p][12], rcb[p][4]})
         rd(12'(rimr_pkg::A_REF0 + p), d);
         `CHK(d, refs[p] & 16'h001f)
         `CHK({ref_auto_out[p], ref_link_out[p]}, refs[p][4:0])
      end
      for (int g = 0; g < 4; g++) begin
         rd(12'(rimr_pkg::A_INT0 + g), d);
         `CHK(d, intr[g] & rimr_pkg::INT_MASK)
      end
      // change fifo: overfill link 3, two entries on link 12
      repeat (5) push(3);
      repeat (2) push(12);
      rd(rimr_pkg::A_FLAGS, d);
      `CHK(d, 16'h1008)
      repeat (5) pop(3);
      pop(12);
      rd(rimr_pkg::A_FLAGS, d);
      `CHK(d, 16'h1000)
      pop(12);
      rd(rimr_pkg::A_FLAGS, d);
      `CHK(d, 16'h0000)
      // external memory access: transfer, no access, initialise
      ext(16'h0001, 1'b1);
      ext(16'h0022, 1'b0);
      ext(16'h0020, 1'b1);
      // integration periods
      n_rsvd = 0;
      period(0, 256);
      period(1, 512);
      period(5, 256);
      `CHK(n_rsvd, 0)
      results();
   end
endmodule
